/* pkg/meter_pkg.sv */
// Package: constants, types and state layouts for the energy pulse rate converter.
package meter_pkg;

    // ********************************************************************
    // Widths and carriers
    // ********************************************************************
    localparam int PWR_W = 24;
    localparam int SUM_W = 27;
    localparam int ACC_W = 40;
    localparam int CNT_W = 32;
    localparam int DAT_W = 32;
    localparam int ADDR_W = 4;
    localparam int EV_W = 3;
    localparam int CODE_W = 3;
    localparam int MULT_W = 8;

    typedef logic [CNT_W-1:0] cnt_t;
    typedef logic [ACC_W-1:0] acc_t;
    typedef logic [MULT_W-1:0] mult_t;

    // Filtered active power of each phase, one signed word per phase.
    typedef struct packed {
        logic signed [PWR_W-1:0] a;
        logic signed [PWR_W-1:0] b;
        logic signed [PWR_W-1:0] c;
    } phase_power_s;

    // Select pins, packed so that the struct value is the select code.
    typedef struct packed {
        logic cal_rate_select;
        logic rate_select_high;
        logic rate_select_low;
    } rate_sel_s;

    // ********************************************************************
    // Transfer function
    // ********************************************************************
    localparam int CLK_HZ_DEFAULT = 40_000_000;
    localparam longint MS_PER_S = 1000;
    localparam longint TICKS_PER_HZ = 1024;
    localparam longint FS_PRODUCT = 64'h0000_0000_0080_0000;
    localparam longint FS_INPUT_MV = 500;
    localparam longint VREF_MV = 2400;
    localparam longint SCALE_MILLI = 6181;
    localparam longint FULL_THR = ((VREF_MV * VREF_MV * MS_PER_S / SCALE_MILLI)
                                   * TICKS_PER_HZ * FS_PRODUCT) / (FS_INPUT_MV * FS_INPUT_MV);
    localparam longint NOLOAD_PPM = 75;
    localparam longint PPM_DEN = 1_000_000;
    localparam longint NOLOAD_MAG = 3 * FS_PRODUCT * NOLOAD_PPM / PPM_DEN;

    // Base frequency in millihertz and calibration multiple, indexed by select code.
    localparam longint BASE_MHZ [8] = '{2300, 1150, 5220, 580, 4610, 4610, 1150, 580};
    localparam longint CAL_MULT [8] = '{16, 32, 160, 32, 8, 16, 16, 16};

    // ********************************************************************
    // Pulse timing in milliseconds
    // ********************************************************************
    localparam longint SLOW_WIDTH_MS = 120;
    localparam longint SLOW_SHORT_MS = 550;
    localparam longint CAL_WIDTH_MS = 90;
    localparam longint CAL_SHORT_MS = 190;

    // ********************************************************************
    // Register map
    // ********************************************************************
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] REG_MASK = 4'h4;
    localparam logic [ADDR_W-1:0] REG_STATE = 4'h8;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'hC;
    localparam int EV_CAL = 0;
    localparam int EV_SLOW = 1;
    localparam int EV_REV = 2;
    localparam int STATE_REV = 0;
    localparam int STATE_MODE = 1;
    localparam int STATE_CODE = 2;
    localparam int CTRL_ENABLE = 0;
    localparam logic CTRL_ENABLE_RESET = 1'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ********************************************************************
    // State layouts
    // ********************************************************************
    typedef struct packed {
        cnt_t period_cnt;
        cnt_t width_cnt;
        logic pulse;
    } shaper_state_s;

    typedef struct packed {
        logic [CODE_W:0] sync1;
        logic [CODE_W:0] sync2;
        cnt_t tick_cnt;
        acc_t acc;
        mult_t half_cnt;
        logic rev;
        logic slow_sel;
        logic [EV_W-1:0] status;
        logic [EV_W-1:0] mask;
        logic enable;
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] waddr;
        logic [DAT_W-1:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [DAT_W-1:0] rdata;
        logic [1:0] rresp;
    } top_state_s;

    // Calibration threshold for one select code.
    function automatic acc_t cal_thr(input int code);
        cal_thr = ACC_W'(FULL_THR / CAL_MULT[code]);
    endfunction : cal_thr

    // Whole clock cycles in a time, rounded down.
    function automatic cnt_t ms_cycles(input longint clk_hz, input longint ms);
        ms_cycles = CNT_W'(clk_hz * ms / MS_PER_S);
    endfunction : ms_cycles

endpackage : meter_pkg

/* verilog/energy_pulse_rate_converter.sv */
// Design: summing, pulse rate conversion, pulse shaping and register slave of the meter.
// How it works
// RL1: Sum-mode pin high totals signed phase powers, low totals their absolute values.
// RL2: In absolute mode every phase counts positive, even when its power is negative.
// RL3: The reverse flag always follows the signed three-phase sum, whatever the mode.
// RL4: Summed power becomes a pulse rate shown as high pulses on both slow outputs.
// RL5: Slow rate scales with summed products times base frequency, 6.181, over vref squared.
// RL6: The three select pins pick one of eight table entries, holding five distinct base frequencies.
// RL7: Each base frequency is a division of the master clock.
// RL8: Slow pulses come from long accumulation, so they follow average power.
// RL9: The calibration output uses the same power accumulated over a short period.
// RL10: Calibration rate is a select-dependent multiple of the slow output rate.
// RL11: Full-scale inputs give the select-dependent maximum slow rate.
// RL12: Reverse flag is high for a negative sum and changes only with calibration pulses.
// RL13: Slow outputs alternate 120 ms pulses, half the period below 550 ms.
// RL14: Calibration pulses are 90 ms wide, half the period below 190 ms.
// RL15: No pulse at all while load is under 0.0075 percent of full scale.
// RL16: Accumulate every tick, pulse on crossing the threshold, keep the remainder.

// ************************************************************************
// Pulse shaper: fixed width, or half the last period when periods are short
// ************************************************************************
module pulse_shaper #(
    parameter meter_pkg::cnt_t WIDE = 1,
    parameter meter_pkg::cnt_t SHORT = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic fire,
    output logic pulse
);
    import meter_pkg::*;

    shaper_state_s q;
    shaper_state_s n;

    // Period starts saturated so the first pulse after reset gets the full width.
    always_comb begin
        n = q;
        if (q.period_cnt != '1) begin
            n.period_cnt = q.period_cnt + 1'b1;
        end
        if (q.width_cnt != '0) begin
            n.width_cnt = q.width_cnt - 1'b1;
        end
        if (fire) begin
            n.period_cnt = '0;
            n.width_cnt = (q.period_cnt < SHORT) ? (q.period_cnt >> 1) : WIDE; // RL13 RL14
            if (n.width_cnt == '0) begin
                n.width_cnt = cnt_t'(1);
            end
        end
        n.pulse = (n.width_cnt != '0);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{period_cnt: '1, width_cnt: '0, pulse: 1'b0};
        end else begin
            q <= n;
        end
    end

    assign pulse = q.pulse;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence long_gap_fire;
        fire && q.period_cnt >= SHORT;
    endsequence

    chk_pulse_starts: assert property (fire |=> pulse) // RL14
        else $error("Shaper did not raise its pulse after a fire.");
    chk_width_full: assert property (long_gap_fire |=> q.width_cnt == WIDE) // RL13
        else $error("Shaper width is not the full width after a long period.");
endmodule : pulse_shaper

// ************************************************************************
// Top: summing, rate conversion and register slave
// ************************************************************************
module energy_pulse_rate_converter #(
    parameter int CLK_HZ = meter_pkg::CLK_HZ_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire meter_pkg::phase_power_s phase_power,
    input wire logic sum_mode_select,
    input wire meter_pkg::rate_sel_s rate_select,
    output logic slow_pulse_out_a,
    output logic slow_pulse_out_b,
    output logic calibration_pulse_out,
    output logic reverse_power_flag,
    output logic irq,
    input wire logic awvalid,
    output logic awready,
    input wire logic [meter_pkg::ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [meter_pkg::DAT_W-1:0] wdata,
    input wire logic [meter_pkg::DAT_W/8-1:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [meter_pkg::ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [meter_pkg::DAT_W-1:0] rdata,
    output logic [1:0] rresp
);
    import meter_pkg::*;

    // Tick period per select code: the accumulator runs at base frequency times a fixed factor.
    function automatic cnt_t tick_div(input int code);
        tick_div = CNT_W'(longint'(CLK_HZ) * MS_PER_S / (BASE_MHZ[code] * TICKS_PER_HZ));
    endfunction : tick_div

    localparam cnt_t TICK_DIV [8] = '{tick_div(0), tick_div(1), tick_div(2), tick_div(3),
                                      tick_div(4), tick_div(5), tick_div(6), tick_div(7)};
    localparam acc_t CAL_THR [8] = '{cal_thr(0), cal_thr(1), cal_thr(2), cal_thr(3), // RL11
                                     cal_thr(4), cal_thr(5), cal_thr(6), cal_thr(7)};
    localparam cnt_t SLOW_WIDE = ms_cycles(CLK_HZ, SLOW_WIDTH_MS);
    localparam cnt_t SLOW_SHORT = ms_cycles(CLK_HZ, SLOW_SHORT_MS);
    localparam cnt_t CAL_WIDE = ms_cycles(CLK_HZ, CAL_WIDTH_MS);
    localparam cnt_t CAL_SHORT = ms_cycles(CLK_HZ, CAL_SHORT_MS);
    localparam logic [SUM_W-1:0] NOLOAD = SUM_W'(NOLOAD_MAG);

    top_state_s q;
    top_state_s n;
    logic [CODE_W-1:0] code;
    logic mode;
    logic tick;
    logic signed [SUM_W-1:0] sum_signed;
    logic [SUM_W-1:0] signed_mag;
    logic [SUM_W-1:0] abs_sum;
    logic [SUM_W-1:0] total_mag;
    acc_t acc_sum;
    mult_t half_mult;
    logic cal_fire;
    logic slow_fire;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;
    logic w_ok;
    logic cal_pulse;
    logic slow_pulse_a;
    logic slow_pulse_b;

    // Pins are sampled through two flops; only the second stage is decoded.
    assign mode = q.sync2[CODE_W];
    assign code = q.sync2[CODE_W-1:0]; // RL6
    assign tick = (q.tick_cnt >= TICK_DIV[code] - 1'b1); // RL7

    // Signed and absolute totals of the three phases.
    assign sum_signed = SUM_W'(phase_power.a) + SUM_W'(phase_power.b) + SUM_W'(phase_power.c);
    assign signed_mag = sum_signed[SUM_W-1] ? SUM_W'(-sum_signed) : sum_signed;
    assign abs_sum = SUM_W'(phase_power.a[PWR_W-1] ? -phase_power.a : phase_power.a)
                   + SUM_W'(phase_power.b[PWR_W-1] ? -phase_power.b : phase_power.b)
                   + SUM_W'(phase_power.c[PWR_W-1] ? -phase_power.c : phase_power.c); // RL2
    assign total_mag = mode ? signed_mag : abs_sum; // RL1

    // Creep guard drops a sample below the no-load level instead of letting it accumulate.
    assign acc_sum = q.acc + ((tick && q.enable && total_mag >= NOLOAD) // RL15 RL5
                     ? ACC_W'(total_mag) : '0);
    assign cal_fire = (acc_sum >= CAL_THR[code]); // RL16 RL9
    assign half_mult = MULT_W'(CAL_MULT[code] >> 1);
    assign slow_fire = cal_fire && (q.half_cnt >= half_mult - 1'b1); // RL10 RL8
    assign ev_set = {(cal_fire && q.rev != sum_signed[SUM_W-1]), slow_fire, cal_fire};
    assign w_ok = (q.waddr == REG_STATUS) || (q.waddr == REG_MASK) || (q.waddr == REG_CTRL);
    assign ev_clr = (q.aw_got && q.w_got && q.wstrb0 && q.waddr == REG_STATUS)
                    ? q.wdata[EV_W-1:0] : '0;

    // Next state: conversion first, then the register slave.
    always_comb begin
        n = q;
        n.sync1 = {sum_mode_select, rate_select};
        n.sync2 = q.sync1;
        n.tick_cnt = tick ? '0 : q.tick_cnt + 1'b1;
        n.acc = cal_fire ? acc_sum - CAL_THR[code] : acc_sum; // RL16
        if (cal_fire) begin
            n.half_cnt = slow_fire ? '0 : q.half_cnt + 1'b1;
            n.rev = sum_signed[SUM_W-1]; // RL3 RL12
        end
        if (slow_fire) begin
            n.slow_sel = ~q.slow_sel; // RL13
        end
        // A new event wins over a clear that lands in the same cycle.
        n.status = (q.status & ~ev_clr) | ev_set;
        if (awvalid && awready) begin
            n.aw_got = 1'b1;
            n.waddr = awaddr;
        end
        if (wvalid && wready) begin
            n.w_got = 1'b1;
            n.wdata = wdata;
            n.wstrb0 = wstrb[0];
        end
        if (q.aw_got && q.w_got) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = w_ok ? RESP_OKAY : RESP_SLVERR;
            if (q.wstrb0 && q.waddr == REG_MASK) begin
                n.mask = q.wdata[EV_W-1:0];
            end
            if (q.wstrb0 && q.waddr == REG_CTRL) begin
                n.enable = q.wdata[CTRL_ENABLE];
            end
        end
        if (q.bvalid && bready) begin
            n.bvalid = 1'b0;
        end
        if (q.rvalid && rready) begin
            n.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            n.rvalid = 1'b1;
            n.rresp = RESP_OKAY;
            n.rdata = '0;
            unique case (araddr)
                REG_STATUS: n.rdata[EV_W-1:0] = q.status;
                REG_MASK: n.rdata[EV_W-1:0] = q.mask;
                REG_STATE: n.rdata[STATE_CODE+CODE_W-1:0] = {code, mode, q.rev};
                REG_CTRL: n.rdata[CTRL_ENABLE] = q.enable;
                default: n.rresp = RESP_SLVERR;
            endcase
        end
    end

    // Everything clears on reset except the enable, which starts on.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.enable <= CTRL_ENABLE_RESET;
        end else begin
            q <= n;
        end
    end

    // ********************************************************************
    // Output pulse shaping
    // ********************************************************************
    // Each slow output measures its own period, so alternation halves neither width rule.
    pulse_shaper #(.WIDE(CAL_WIDE), .SHORT(CAL_SHORT)) u_cal_shaper (
        .clk(clk), .rst_n(rst_n), .fire(cal_fire), .pulse(cal_pulse)); // RL14
    pulse_shaper #(.WIDE(SLOW_WIDE), .SHORT(SLOW_SHORT)) u_slow_a_shaper (
        .clk(clk), .rst_n(rst_n), .fire(slow_fire && !q.slow_sel), .pulse(slow_pulse_a)); // RL4
    pulse_shaper #(.WIDE(SLOW_WIDE), .SHORT(SLOW_SHORT)) u_slow_b_shaper (
        .clk(clk), .rst_n(rst_n), .fire(slow_fire && q.slow_sel), .pulse(slow_pulse_b)); // RL4

    assign calibration_pulse_out = cal_pulse;
    assign slow_pulse_out_a = slow_pulse_a;
    assign slow_pulse_out_b = slow_pulse_b;
    assign reverse_power_flag = q.rev;
    assign irq = |(q.status & q.mask);
    assign awready = !q.aw_got && !q.bvalid;
    assign wready = !q.w_got && !q.bvalid;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign arready = !q.rvalid;
    assign rvalid = q.rvalid;
    assign rdata = q.rdata;
    assign rresp = q.rresp;

    // ********************************************************************
    // Checks
    // ********************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence cal_on_negative;
        cal_fire && sum_signed < 0;
    endsequence

    chk_abs_dominates: assert property (!mode |-> total_mag >= signed_mag) // RL2
        else $error("Absolute total is below the signed magnitude.");
    chk_signed_mode: assert property (mode |-> total_mag == signed_mag) // RL1
        else $error("Signed mode does not use the signed total.");
    chk_rev_negative: assert property (cal_on_negative |=> reverse_power_flag) // RL3
        else $error("Reverse flag not raised on a negative sum.");
    chk_rev_holds: assert property (!cal_fire |=> $stable(reverse_power_flag)) // RL12
        else $error("Reverse flag moved without a calibration pulse.");
    chk_noload_hold: assert property ( // RL15
        total_mag < NOLOAD && !cal_fire |=> q.acc == $past(q.acc))
        else $error("Accumulator grew below the no-load level.");
    chk_acc_remainder: assert property (cal_fire |=> q.acc < $past(CAL_THR[code])) // RL16
        else $error("Remainder after a pulse is not below the threshold.");
    chk_slow_ratio: assert property ( // RL10
        slow_fire |-> cal_fire && q.half_cnt == half_mult - 1'b1)
        else $error("Slow pulse not at the calibration multiple.");
    chk_slow_alternate: assert property (slow_fire |=> q.slow_sel != $past(q.slow_sel)) // RL13
        else $error("Slow outputs did not alternate.");
    // A divider of one makes every cycle a tick, so spacing is only checked above that.
    chk_tick_spacing: assert property (tick ##1 (TICK_DIV[code] > cnt_t'(1)) |-> !tick) // RL7
        else $error("Base tick came on consecutive cycles.");
endmodule : energy_pulse_rate_converter

/* dv/pulse_counter_model.sv */
// Partner model: a pulse counter that times the slow and calibration outputs.
module pulse_counter_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] pins,
    output int rises [3],
    output int width [3],
    output int period [3]
);
    timeunit 1ns;
    timeprecision 1ps;
    int now;
    int last [3];
    logic [2:0] prev;

    // Count cycles, then time each rising edge and each high stretch of every pin.
    // Edges are seen one cycle late, which cancels out of every difference.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            now = 0;
            prev = 3'h0;
            for (int i = 0; i < 3; i++) begin
                rises[i] = 0;
                last[i] = 0;
            end
        end else begin
            now = now + 1;
            for (int i = 0; i < 3; i++) begin
                if (pins[i] && !prev[i]) begin
                    rises[i] = rises[i] + 1;
                    period[i] = now - last[i];
                    last[i] = now;
                end
                if (!pins[i] && prev[i]) begin
                    width[i] = now - last[i];
                end
            end
            prev = pins;
        end
    end
endmodule : pulse_counter_model

/* dv/energy_pulse_rate_converter_tb_top.sv */
// Testbench: drives the meter back end and checks its pulse outputs and registers.
module energy_pulse_rate_converter_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import meter_pkg::*;

    // ********************************************************************
    // Stimulus and design
    // ********************************************************************
    localparam int HZ = 6000;
    localparam longint F = 24'h7f_ffff;
    localparam int LIMIT = 80000;
    typedef struct {int ra; int rb; int cals; longint lo; longint hi;} note_s;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    phase_power_s phase_power = '0;
    logic sum_mode_select = 1'b1;
    rate_sel_s rate_select = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic bready = 1'b0;
    logic rready = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0;
    logic [ADDR_W-1:0] araddr = '0;
    logic [DAT_W-1:0] wdata = '0;
    logic [DAT_W/8-1:0] wstrb = 4'hf;
    logic slow_pulse_out_a, slow_pulse_out_b, calibration_pulse_out, reverse_power_flag, irq;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [DAT_W-1:0] rdata;
    int rises [3], width [3], period [3];
    int fail_count = 0, total_checks = 0, cycles = 0, seen = 0, mark = 0;
    longint t_slow, d, t, c1;
    note_s n;
    note_s exp_q [$];
    logic flag_prev = 1'b0, cal_prev = 1'b0;

    always #12.5 clk = ~clk;

    energy_pulse_rate_converter #(.CLK_HZ(HZ)) i_energy_pulse_rate_converter (
        .clk(clk), .rst_n(rst_n), .phase_power(phase_power), .sum_mode_select(sum_mode_select),
        .rate_select(rate_select), .slow_pulse_out_a(slow_pulse_out_a),
        .slow_pulse_out_b(slow_pulse_out_b), .calibration_pulse_out(calibration_pulse_out),
        .reverse_power_flag(reverse_power_flag), .irq(irq), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp));

    pulse_counter_model i_pulse_counter_model (.clk(clk), .rst_n(rst_n),
        .pins({calibration_pulse_out, slow_pulse_out_b, slow_pulse_out_a}),
        .rises(rises), .width(width), .period(period));

    // ********************************************************************
    // Tasks
    // ********************************************************************
    task automatic chk(input string nm, input logic [63:0] sv, input logic [63:0] ev);
        total_checks++;
        if (sv !== ev) begin
            fail_count++;
            $display("MISMATCH %s expected %0h seen %0h", nm, ev, sv);
        end
    endtask : chk

    task automatic end_sim();
        if (fail_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    task automatic do_reset(input logic [2:0] code);
        @(posedge clk);
        rate_select <= code;
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
    endtask : do_reset

    task automatic set_pw(input longint pa, input longint pb, input longint pc);
        @(posedge clk);
        phase_power <= {PWR_W'(pa), PWR_W'(pb), PWR_W'(pc)};
    endtask : set_pw

    // Address and data are offered together and each is dropped once taken.
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] dv, input logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= dv;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            aw_ok = aw_ok | (awready === 1'b1);
            w_ok = w_ok | (wready === 1'b1);
            awvalid <= !aw_ok;
            wvalid <= !w_ok;
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", bresp, r);
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a, input logic [31:0] dv, input logic [1:0] r);
        @(posedge clk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk("rdata", rdata, dv);
        chk("rresp", rresp, r);
    endtask : axi_rd

    // Counts calibration pulses over a fixed window; the tick phase is unknown, hence slack.
    task automatic rate_chk(input logic mode, input longint tot);
        longint c0;
        longint e;
        @(posedge clk);
        sum_mode_select <= mode;
        repeat (10) @(negedge clk);
        c0 = rises[2];
        repeat (600) @(negedge clk);
        e = 600 * tot / (FULL_THR / CAL_MULT[2]);
        chk("cal rate", (rises[2] - c0 > e - 3) && (rises[2] - c0 < e + 3), 1'b1);
    endtask : rate_chk

    // ********************************************************************
    // Monitors and main sequence
    // ********************************************************************
    // While notes remain, each new slow pulse takes the oldest note off the queue and is compared with it.
    always @(negedge clk) begin
        if (!rst_n) begin
            seen = 0;
            mark = 0;
        end else if (rises[0] + rises[1] != seen) begin
            seen = rises[0] + rises[1];
            if (exp_q.size() > 0) begin
                n = exp_q.pop_front();
                chk("slow order", {rises[0], rises[1]}, {n.ra, n.rb});
                chk("cal per slow", rises[2] - mark, n.cals);
                if (n.hi > 0) begin
                    chk("gap", cycles - t_slow inside {[n.lo:n.hi]}, 1'b1);
                end
            end
            mark = rises[2];
            t_slow = cycles;
        end
    end

    // The reverse flag may move only in the cycle in which a calibration pulse begins.
    always @(negedge clk) begin
        if (rst_n && flag_prev !== reverse_power_flag) begin
            chk("flag with cal", calibration_pulse_out && !cal_prev, 1'b1);
        end
        flag_prev = reverse_power_flag;
        cal_prev = calibration_pulse_out;
    end

    // Hang guard: a run past the limit counts as a failure.
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == LIMIT) begin
            fail_count = fail_count + 1;
            end_sim();
        end
    end

    // Select codes, sum modes, no-load, then the register bus and interrupt.
    initial begin
        void'($urandom(70333));
        set_pw(F, F, F);
        for (int k = 0; k < 8; k++) begin
            do_reset(3'(k));
            d = longint'(HZ) * 1000 / (BASE_MHZ[k] * 1024);
            t = FULL_THR / (2 * 3 * F);
            // The first cal pulse is full width and swallows the next rise if that comes sooner.
            c1 = FULL_THR / CAL_MULT[k] / (3 * F) * d;
            c1 = CAL_MULT[k] / 2 - ((c1 < CAL_WIDTH_MS * HZ / 1000) ? 1 : 0);
            exp_q.push_back('{1, 0, int'(c1), 0, 0});
            exp_q.push_back('{1, 1, int'(CAL_MULT[k] / 2), t * d, (t + 1) * d});
            while (exp_q.size() > 0 || slow_pulse_out_a !== 1'b0) @(negedge clk);
            @(negedge clk);
            chk("first slow width", width[0], SLOW_WIDTH_MS * HZ / 1000);
        end
        do_reset(3'h2);
        set_pw(F, F, -F);
        rate_chk(1'b1, F);
        chk("flag", reverse_power_flag, 1'b0);
        rate_chk(1'b0, 3 * F);
        chk("flag", reverse_power_flag, 1'b0);
        set_pw(-F, -F, -F);
        rate_chk(1'b0, 3 * F);
        chk("flag", reverse_power_flag, 1'b1);
        rate_chk(1'b1, 3 * F);
        chk("flag", reverse_power_flag, 1'b1);
        chk("cal half width", (2 * width[2] - period[2]) ** 2 <= 4, 1'b1);
        while (rises[0] < 3 || slow_pulse_out_a !== 1'b0) @(negedge clk);
        @(negedge clk);
        chk("slow half width", (2 * width[0] - period[0]) ** 2 <= 4, 1'b1);
        // Random loads stay below the creep threshold in either sum mode.
        set_pw(longint'($urandom_range(1200)) - 600, longint'($urandom_range(1200)) - 600,
            longint'($urandom_range(1200)) - 600);
        sum_mode_select <= 1'($urandom_range(1));
        repeat (20) @(negedge clk);
        t = rises[0] + rises[1] + rises[2];
        repeat (2000) @(negedge clk);
        chk("no-load pulses", rises[0] + rises[1] + rises[2] - t, 0);
        do_reset(3'h2);
        set_pw(F, F, F);
        sum_mode_select <= 1'b1;
        axi_rd(REG_CTRL, 32'h0000_0001, RESP_OKAY);
        axi_rd(REG_MASK, 32'h0000_0000, RESP_OKAY);
        repeat (40) @(negedge clk);
        chk("irq masked", irq, 1'b0);
        axi_rd(REG_STATUS, 32'h0000_0001, RESP_OKAY);
        axi_wr(REG_CTRL, 32'h0000_0000, RESP_OKAY);
        repeat (20) @(posedge clk);
        axi_wr(REG_STATUS, 32'h0000_0007, RESP_OKAY);
        axi_rd(REG_STATUS, 32'h0000_0000, RESP_OKAY);
        axi_wr(REG_MASK, 32'h0000_0001, RESP_OKAY);
        @(negedge clk);
        chk("irq cleared", irq, 1'b0);
        axi_wr(REG_CTRL, 32'h0000_0001, RESP_OKAY);
        repeat (30) @(negedge clk);
        chk("irq raised", irq, 1'b1);
        axi_rd(REG_STATE, 32'h0000_000a, RESP_OKAY);
        axi_rd(4'h2, 32'h0000_0000, RESP_SLVERR);
        axi_wr(4'h2, 32'h0000_0001, RESP_SLVERR);
        end_sim();
    end
endmodule : energy_pulse_rate_converter_tb_top
